// File: verilog/ptm_map.vh
// Register map, field layout, limits and timing constants of the pilot tone input monitor
`ifndef PTM_MAP_VH
`define PTM_MAP_VH
// Register word indices
`define PTM_ADR_CTRL 4'h0
`define PTM_ADR_ENA 4'h1
`define PTM_ADR_DTIME 4'h2
`define PTM_ADR_TUNE_A 4'h3
`define PTM_ADR_TUNE_B 4'h4
`define PTM_ADR_THR 4'h5
`define PTM_ADR_STAT 4'h6
`define PTM_ADR_LEVEL 4'h7
`define PTM_ADR_COUNT 4'h8
`define PTM_ADR_ISTAT 4'h9
`define PTM_ADR_IMASK 4'hA
// Field positions
`define PTM_CTRL_DIG 0
`define PTM_CTRL_MODE 2:1
`define PTM_TUNE_FREQ 14:0
`define PTM_TUNE_FINE 23:16
`define PTM_TUNE_Q 29:24
// Supervision types
`define PTM_MODE_APIL 2'h0
`define PTM_MODE_DPIL 2'h1
`define PTM_MODE_DLCK 2'h2
// Setting limits
`define PTM_FREQ_MIN 15'h0001
`define PTM_FREQ_MAX 15'h4E20
`define PTM_FINE_MIN 8'h9C
`define PTM_FINE_MAX 8'h64
`define PTM_Q_MIN 6'h04
`define PTM_Q_MAX 6'h2A
`define PTM_THR_MIN 8'h86
`define PTM_THR_MAX 8'h15
// Reset values
`define PTM_CTRL_RST 3'h0
`define PTM_ENA_RST 4'h0
`define PTM_DTIME_RST 16'h03E8
`define PTM_TUNE_RST 30'h14004A38
`define PTM_THR_RST 8'hD6
// Filter scaling
`define PTM_KF 7'h16
`define PTM_HZ_CENTI 7'h64
`define PTM_QONE 17'h10000
`define PTM_DB_OFS 8'h72
`define PTM_DB_FLOOR 8'h80
`define PTM_DB_STEP 8'h06
`define PTM_DB_HALF 8'h03
`define PTM_ENV_DEC 12
// Largest stable frequency coefficient, 1.75 in Q24
`define PTM_FC_MAX 27'h1C00000
// Timing
`define PTM_CLK_NS 20
`define PTM_MS_NS 1000000
`endif

// File: verilog/ptm_svf.v
// State variable notch filter with band level meter in dBu
`timescale 1ns/1ns
`include "ptm_map.vh"
module ptm_svf (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Sample input
  input wire i_stb,
  input wire signed [23:0] i_x,
  // Tuning coefficients
  input wire [26:0] i_fc,
  input wire [16:0] i_qc,
  // Results
  output reg signed [23:0] o_y,
  output reg signed [7:0] o_db
);
  reg signed [31:0] lp_reg; // Low pass state
  reg signed [31:0] bp_reg; // Band pass state
  reg [22:0] env_reg; // Band envelope
  reg [22:0] env_next;
  reg signed [7:0] db_next;
  reg [4:0] msb;
  integer k;
  // Chamberlin update; notch output is hp + lp, zero at the centre
  wire signed [59:0] f_bp = $signed({1'b0, i_fc}) * bp_reg;
  wire signed [31:0] lp_n = lp_reg + f_bp[55:24];
  wire signed [49:0] q_bp = $signed({1'b0, i_qc}) * bp_reg;
  wire signed [31:0] hp = {{8{i_x[23]}}, i_x} - lp_n - q_bp[47:16];
  wire signed [59:0] f_hp = $signed({1'b0, i_fc}) * hp;
  wire signed [31:0] bp_n = bp_reg + f_hp[55:24];
  wire signed [31:0] nt = hp + lp_n;
  wire [31:0] bp_mag = bp_n[31] ? (~bp_n + 32'h00000001) : bp_n;
  // Saturate notch output to the sample width
  wire signed [23:0] nt_sat = (nt > 32'sh007FFFFF) ? 24'h7FFFFF :
                              (nt < -32'sh00800000) ? 24'h800000 : nt[23:0];
  // Peak envelope with slow decay, then log2 to 6 dB per bit
  always @* begin
    env_next = env_reg - (env_reg >> `PTM_ENV_DEC);
    // Shift decay stalls on small values; step by one so silence reaches the floor
    if (env_next == env_reg && env_reg != 23'h000000)
      env_next = env_reg - 23'h000001;
    if (bp_mag[31:23] != 9'h000)
      env_next = 23'h7FFFFF;
    else if (bp_mag[22:0] > env_next)
      env_next = bp_mag[22:0];
    msb = 5'h00;
    for (k = 1; k < 23; k = k + 1)
      if (env_reg[k])
        msb = k[4:0];
    if (env_reg == 23'h000000)
      db_next = `PTM_DB_FLOOR;
    else if (msb != 5'h00 && env_reg[msb - 5'h01])
      db_next = {3'h0, msb} * `PTM_DB_STEP + `PTM_DB_HALF - `PTM_DB_OFS;
    else
      db_next = {3'h0, msb} * `PTM_DB_STEP - `PTM_DB_OFS;
  end
  // State advances once per sample strobe
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lp_reg <= 32'h00000000;
      bp_reg <= 32'h00000000;
      env_reg <= 23'h000000;
      o_y <= 24'h000000;
      o_db <= `PTM_DB_FLOOR;
    end else begin
      o_db <= db_next;
      if (i_stb) begin
        lp_reg <= lp_n;
        bp_reg <= bp_n;
        env_reg <= env_next;
        o_y <= nt_sat;
      end
    end
  end
endmodule // ptm_svf

// File: verilog/ptm_absence.v
// Absence timer that turns a missing pilot or lock into a fault
`timescale 1ns/1ns
`include "ptm_map.vh"
module ptm_absence (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Timing
  input wire i_ms_tick,
  input wire [15:0] i_limit,
  // Conditions
  input wire i_enable,
  input wire i_detect,
  input wire i_unavail,
  // Fault level
  output reg o_fault
);
  reg [15:0] gap_reg; // Milliseconds without detection
  // Gap counter, restarted by any detection
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gap_reg <= 16'h0000;
      o_fault <= 1'b0;
    end else begin
      if (!i_enable || i_detect)
        gap_reg <= 16'h0000;
      else if (i_ms_tick && gap_reg != 16'hFFFF)
        gap_reg <= gap_reg + 16'h0001;
      // Fault once the gap is longer than the limit, or at once while unavailable
      o_fault <= i_enable && (i_unavail || (!i_detect && gap_reg > i_limit));
    end
  end
endmodule // ptm_absence

// File: verilog/ptm_monitor.v
// Pilot tone input monitor: notch filters, pilot or lock supervision, fault and event logic
`timescale 1ns/1ns
`include "ptm_map.vh"
module ptm_monitor #(
  // Clock cycles per millisecond of detection time
  parameter MS_CYC = `PTM_MS_NS / `PTM_CLK_NS
) (
  // Clock and reset
  input wire I_MCLK,
  input wire I_RST_B,
  // Register port
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // Audio samples, same clock
  input wire I_SMP_STB,
  input wire [23:0] I_ANA_A,
  input wire [23:0] I_ANA_B,
  input wire [23:0] I_AES_A,
  input wire [23:0] I_AES_B,
  // Receiver lock pin, asynchronous
  input wire I_AES_LOCK,
  // Programme path out
  output reg O_PGM_STB,
  output reg [23:0] O_PGM_A,
  output reg [23:0] O_PGM_B,
  // Fault indication
  output reg O_FAULT_A,
  output reg O_FAULT_B,
  output reg O_INPUT_SUPERVISION_FAULT,
  output reg O_IRQ
);
  // Last divider count of one millisecond tick
  localparam [31:0] MS_LAST = MS_CYC - 1;

  // Software settings
  reg [2:0] ctrl_reg; // Input mode and supervision type
  reg [3:0] ena_reg; // Supervision and notch enables
  reg [15:0] dtime_reg; // Detection time in ms
  reg [29:0] tune_reg [0:1]; // Frequency, fine, Q per input
  reg [7:0] thr_reg [0:1]; // Threshold per input in dBu
  reg [16:0] qc_reg [0:1]; // Reciprocal of Q
  reg [26:0] fc_reg [0:1]; // Frequency coefficient
  // Event state
  reg [15:0] count_reg; // Fault occurrence counter
  reg [1:0] istat_reg; // Sticky fault entry bits
  reg [1:0] imask_reg; // Interrupt mask
  reg [1:0] fault_prev_reg; // Last cycle fault levels
  // Timing and synchronisers
  reg [31:0] ms_cnt_reg; // Divider for ms tick
  reg ms_tick_reg; // One cycle per ms
  reg lock_s1_reg; // Lock sync first stage
  reg lock_s2_reg; // Lock sync second stage
  reg stb_d_reg; // Sample strobe delayed to filter output
  reg [23:0] raw_reg [0:1]; // Unfiltered programme sample

  // Per-input wires
  wire [23:0] ana_w [0:1];
  wire [23:0] aes_w [0:1];
  wire [23:0] notch_w [0:1];
  wire [7:0] level_w [0:1];
  wire [1:0] detect_w;
  wire [1:0] fault_w;
  assign ana_w[0] = I_ANA_A;
  assign ana_w[1] = I_ANA_B;
  assign aes_w[0] = I_AES_A;
  assign aes_w[1] = I_AES_B;

  // Decoded settings
  wire dig_mode = ctrl_reg[`PTM_CTRL_DIG];
  wire [1:0] sup_mode = ctrl_reg[`PTM_CTRL_MODE];
  // Digital types cannot work while the inputs are analogue
  wire unavail = !dig_mode && (sup_mode != `PTM_MODE_APIL);
  wire [1:0] fault_rise = fault_w & ~fault_prev_reg;

  // Clamp helpers keep every setting inside its legal range
  function [14:0] clamp_freq;
    input [14:0] v;
    begin
      if (v < `PTM_FREQ_MIN)
        clamp_freq = `PTM_FREQ_MIN;
      else if (v > `PTM_FREQ_MAX)
        clamp_freq = `PTM_FREQ_MAX;
      else
        clamp_freq = v;
    end
  endfunction

  function [7:0] clamp_s8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if ($signed(v) < $signed(lo))
        clamp_s8 = lo;
      else if ($signed(v) > $signed(hi))
        clamp_s8 = hi;
      else
        clamp_s8 = v;
    end
  endfunction

  function [5:0] clamp_q;
    input [5:0] v;
    begin
      if (v < `PTM_Q_MIN)
        clamp_q = `PTM_Q_MIN;
      else if (v > `PTM_Q_MAX)
        clamp_q = `PTM_Q_MAX;
      else
        clamp_q = v;
    end
  endfunction

  // Tuning word from a write, limits applied
  function [29:0] tune_word;
    input [31:0] d;
    begin
      tune_word = `PTM_TUNE_RST;
      tune_word[`PTM_TUNE_FREQ] = clamp_freq(d[`PTM_TUNE_FREQ]);
      tune_word[`PTM_TUNE_FINE] = clamp_s8(d[`PTM_TUNE_FINE], `PTM_FINE_MIN, `PTM_FINE_MAX);
      tune_word[`PTM_TUNE_Q] = clamp_q(d[`PTM_TUNE_Q]);
    end
  endfunction

  // Millisecond tick for the absence timers
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ms_cnt_reg <= 32'h00000000;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == MS_LAST) begin
      ms_cnt_reg <= 32'h00000000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
      ms_tick_reg <= 1'b0;
    end
  end

  // Lock pin synchroniser, second stage feeds the logic
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      lock_s1_reg <= I_AES_LOCK;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // Settings registers; writes are clamped rather than refused
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_reg <= `PTM_CTRL_RST;
      ena_reg <= `PTM_ENA_RST;
      dtime_reg <= `PTM_DTIME_RST;
      tune_reg[0] <= `PTM_TUNE_RST;
      tune_reg[1] <= `PTM_TUNE_RST;
      thr_reg[0] <= `PTM_THR_RST;
      thr_reg[1] <= `PTM_THR_RST;
      imask_reg <= 2'h0;
    end else if (I_WR) begin
      case (I_ADDR)
        `PTM_ADR_CTRL: begin
          // Reserved type code falls back to analogue pilot
          ctrl_reg[`PTM_CTRL_DIG] <= I_WDATA[`PTM_CTRL_DIG];
          ctrl_reg[`PTM_CTRL_MODE] <= (I_WDATA[`PTM_CTRL_MODE] == 2'h3) ?
                                      `PTM_MODE_APIL : I_WDATA[`PTM_CTRL_MODE];
        end
        `PTM_ADR_ENA: ena_reg <= I_WDATA[3:0];
        `PTM_ADR_DTIME: dtime_reg <= I_WDATA[15:0];
        `PTM_ADR_TUNE_A: tune_reg[0] <= tune_word(I_WDATA);
        `PTM_ADR_TUNE_B: tune_reg[1] <= tune_word(I_WDATA);
        `PTM_ADR_THR: begin
          thr_reg[0] <= clamp_s8(I_WDATA[7:0], `PTM_THR_MIN, `PTM_THR_MAX);
          thr_reg[1] <= clamp_s8(I_WDATA[15:8], `PTM_THR_MIN, `PTM_THR_MAX);
        end
        `PTM_ADR_IMASK: imask_reg <= I_WDATA[1:0];
        default: ctrl_reg <= ctrl_reg; // Read-only or unmapped
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_in
      // Centre in hundredths of a hertz, fine offset signed
      wire [21:0] centi = tune_reg[g][`PTM_TUNE_FREQ] * `PTM_HZ_CENTI
                          + {{14{tune_reg[g][23]}}, tune_reg[g][`PTM_TUNE_FINE]};
      wire [28:0] fc_full = centi * `PTM_KF;
      // Monitored source: analogue connector, or stream channel for digital pilot in digital mode
      wire [23:0] mon_src = (sup_mode == `PTM_MODE_DPIL && dig_mode) ? aes_w[g] : ana_w[g];
      // Programme source follows the input mode only
      wire [23:0] pgm_src = dig_mode ? aes_w[g] : ana_w[g];

      // Coefficients are refreshed every cycle; divide is slow but rare in change
      always @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          qc_reg[g] <= 17'h00000;
          fc_reg[g] <= 27'h0000000;
          raw_reg[g] <= 24'h000000;
        end else begin
          qc_reg[g] <= `PTM_QONE / {11'h000, tune_reg[g][`PTM_TUNE_Q]};
          // Clamp keeps the loop stable at any Q; very high centres sit low
          fc_reg[g] <= (fc_full[26:0] > `PTM_FC_MAX) ? `PTM_FC_MAX : fc_full[26:0];
          if (I_SMP_STB)
            raw_reg[g] <= pgm_src;
        end
      end

      // Programme notch: runs from its own enable, not the supervision one
      // Its meter output is not needed on the programme side
      ptm_svf u_pgm (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_stb(I_SMP_STB),
        .i_x(pgm_src),
        .i_fc(fc_reg[g]),
        .i_qc(qc_reg[g]),
        .o_y(notch_w[g]),
        .o_db()
      );

      // Level meter at the pilot frequency on the supervised source
      ptm_svf u_mon (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_stb(I_SMP_STB),
        .i_x(mon_src),
        .i_fc(fc_reg[g]),
        .i_qc(qc_reg[g]),
        .o_y(),
        .o_db(level_w[g])
      );

      // Detection by level, or by receiver lock
      assign detect_w[g] = (sup_mode == `PTM_MODE_DLCK) ? lock_s2_reg :
                           ($signed(level_w[g]) >= $signed(thr_reg[g]));

      // Mute controls are not inputs here, so they cannot stop it
      ptm_absence u_abs (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_ms_tick(ms_tick_reg),
        .i_limit(dtime_reg),
        .i_enable(ena_reg[g]),
        .i_detect(detect_w[g] && !unavail),
        .i_unavail(unavail),
        .o_fault(fault_w[g])
      );
    end
  endgenerate

  // Programme outputs, two cycles after the sample strobe
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stb_d_reg <= 1'b0;
      O_PGM_STB <= 1'b0;
      O_PGM_A <= 24'h000000;
      O_PGM_B <= 24'h000000;
    end else begin
      stb_d_reg <= I_SMP_STB;
      O_PGM_STB <= stb_d_reg;
      if (stb_d_reg) begin
        O_PGM_A <= ena_reg[2] ? notch_w[0] : raw_reg[0];
        O_PGM_B <= ena_reg[3] ? notch_w[1] : raw_reg[1];
      end
    end
  end

  // Fault outputs and occurrence counter
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      fault_prev_reg <= 2'h0;
      count_reg <= 16'h0000;
      O_FAULT_A <= 1'b0;
      O_FAULT_B <= 1'b0;
      O_INPUT_SUPERVISION_FAULT <= 1'b0;
    end else begin
      fault_prev_reg <= fault_w;
      O_FAULT_A <= fault_w[0];
      O_FAULT_B <= fault_w[1];
      O_INPUT_SUPERVISION_FAULT <= |fault_w;
      // Counts entries of the combined condition; saturates, never wraps
      if ((|fault_w) && !(|fault_prev_reg) && count_reg != 16'hFFFF)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // Sticky entry bits; a new entry beats the clear-on-read
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      istat_reg <= 2'h0;
      O_IRQ <= 1'b0;
    end else begin
      if (I_RD && I_ADDR == `PTM_ADR_ISTAT)
        istat_reg <= fault_rise;
      else
        istat_reg <= istat_reg | fault_rise;
      O_IRQ <= |(istat_reg & imask_reg);
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= 32'h00000000;
    end else if (I_RD) begin
      case (I_ADDR)
        `PTM_ADR_CTRL: O_RDATA <= {29'h0, ctrl_reg};
        `PTM_ADR_ENA: O_RDATA <= {28'h0, ena_reg};
        `PTM_ADR_DTIME: O_RDATA <= {16'h0, dtime_reg};
        `PTM_ADR_TUNE_A: O_RDATA <= {2'h0, tune_reg[0]};
        `PTM_ADR_TUNE_B: O_RDATA <= {2'h0, tune_reg[1]};
        `PTM_ADR_THR: O_RDATA <= {16'h0, thr_reg[1], thr_reg[0]};
        `PTM_ADR_STAT: O_RDATA <= {26'h0, unavail, lock_s2_reg, detect_w, fault_w};
        `PTM_ADR_LEVEL: O_RDATA <= {16'h0, level_w[1], level_w[0]};
        `PTM_ADR_COUNT: O_RDATA <= {16'h0, count_reg};
        `PTM_ADR_ISTAT: O_RDATA <= {30'h0, istat_reg};
        `PTM_ADR_IMASK: O_RDATA <= {30'h0, imask_reg};
        default: O_RDATA <= 32'h00000000; // Unmapped reads zero
      endcase
    end else begin
      O_RDATA <= 32'h00000000;
    end
  end
endmodule // ptm_monitor

// File: testbench/ptm_monitor_sva.sv
// Port-level assertions for the pilot tone input monitor
`timescale 1ns/1ns
`include "ptm_map.vh"
module ptm_chk (
  // Clock and reset
  input wire I_MCLK,
  input wire I_RST_B,
  // Register port
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [31:0] O_RDATA,
  // Audio strobes
  input wire I_SMP_STB,
  input wire O_PGM_STB,
  // Fault indication
  input wire O_FAULT_A,
  input wire O_FAULT_B,
  input wire O_INPUT_SUPERVISION_FAULT,
  input wire O_IRQ
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  // Read data only in the slot after a read
  property p_rd_idle;
    !$past(I_RD) |-> O_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  // Unmapped words read as zero
  property p_rd_unmapped;
    I_RD && (I_ADDR > `PTM_ADR_IMASK) |=> O_RDATA == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped word not zero");
  // Programme sample two cycles after each input sample, notch on or off
  property p_pgm_lat;
    I_SMP_STB |-> ##2 O_PGM_STB;
  endproperty
  a_pgm_lat: assert property (p_pgm_lat) else $error("programme strobe late");
  // No programme strobe without a sample
  property p_pgm_only;
    O_PGM_STB |-> $past(I_SMP_STB, 2);
  endproperty
  a_pgm_only: assert property (p_pgm_only) else $error("stray programme strobe");
  // Combined fault follows a rising input fault
  property p_any_rise;
    $rose(O_FAULT_A) || $rose(O_FAULT_B) |-> ##[0:1] O_INPUT_SUPERVISION_FAULT;
  endproperty
  a_any_rise: assert property (p_any_rise) else $error("combined fault missing");
  // Combined fault never without an input fault
  property p_any_src;
    O_INPUT_SUPERVISION_FAULT |-> O_FAULT_A || O_FAULT_B || $past(O_FAULT_A) || $past(O_FAULT_B);
  endproperty
  a_any_src: assert property (p_any_src) else $error("combined fault without cause");
  // Clearing both enables drops both faults
  property p_ena_off;
    I_WR && I_ADDR == `PTM_ADR_ENA && I_WDATA[1:0] == 2'h0 |-> ##3 !O_FAULT_A && !O_FAULT_B;
  endproperty
  a_ena_off: assert property (p_ena_off) else $error("fault stays with enable off");
  // Status read clears the interrupt unless a new entry arrives
  property p_irq_clr;
    (I_RD && I_ADDR == `PTM_ADR_ISTAT) ##1 (!$rose(O_FAULT_A) && !$rose(O_FAULT_B)) [*2] |-> !O_IRQ;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt stays after status read");
  // Interrupt rises only from a fault entry or a mask write
  property p_irq_cause;
    $rose(O_IRQ) |-> $past(I_WR && I_ADDR == `PTM_ADR_IMASK, 2) ||
      ($past(O_FAULT_A) && !$past(O_FAULT_A, 2)) || ($past(O_FAULT_B) && !$past(O_FAULT_B, 2));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule // ptm_chk
bind ptm_monitor ptm_chk i_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SMP_STB(I_SMP_STB), .O_PGM_STB(O_PGM_STB),
  .O_FAULT_A(O_FAULT_A), .O_FAULT_B(O_FAULT_B), .O_INPUT_SUPERVISION_FAULT(O_INPUT_SUPERVISION_FAULT),
  .O_IRQ(O_IRQ));

// File: testbench/ptm_src.sv
// Audio source model: square pilot samples and receiver lock
`timescale 1ns/1ns
module ptm_src #(
  // Last divider count of each sample period
  parameter [7:0] LAST = 8'h0F
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Commands from the bench
  input wire i_tone_on,
  input wire i_lock_on,
  // Samples and lock
  output reg o_stb,
  output reg [23:0] o_ana_a,
  output reg [23:0] o_ana_b,
  output reg [23:0] o_aes_a,
  output reg [23:0] o_aes_b,
  output reg o_lock
);
  reg [7:0] div_reg; // Sample divider
  reg [7:0] ph_reg; // Tone phase in samples
  wire [23:0] smp = i_tone_on ? (ph_reg[2] ? 24'h200000 : 24'hE00000) : 24'h000000; // Silence when off
  // Data valid only beside the strobe; it toggles between so stale data never looks good
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= 8'h00;
      ph_reg <= 8'h00;
      o_stb <= 1'b0;
      o_ana_a <= 24'h000000;
      o_ana_b <= 24'h000000;
      o_aes_a <= 24'h000000;
      o_aes_b <= 24'h000000;
      o_lock <= 1'b0;
    end else begin
      o_lock <= i_lock_on;
      o_stb <= (div_reg == LAST);
      div_reg <= (div_reg == LAST) ? 8'h00 : div_reg + 8'h01;
      if (div_reg == LAST) begin
        ph_reg <= ph_reg + 8'h01;
        o_ana_a <= smp;
        o_ana_b <= smp;
        o_aes_a <= smp;
        o_aes_b <= ~smp;
      end else begin
        o_ana_a <= ~o_ana_a;
        o_ana_b <= ~o_ana_b;
        o_aes_a <= ~o_aes_a;
        o_aes_b <= ~o_aes_b;
      end
    end
  end
endmodule // ptm_src

// File: testbench/test_pilot_tone_input_monitor.sv
// Self-checking bench for the pilot tone input monitor
`timescale 1ns/1ns
`include "ptm_map.vh"
module test_pilot_tone_input_monitor;
  localparam MS = 10; // Short millisecond keeps fault waits brief
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg tone_on = 1'b1; // Source commands
  reg lock_on = 1'b0;
  reg rd_d = 1'b0; // Read slot marker
  reg [31:0] rnd;
  reg [31:0] exp_q[$]; // Expected read data, oldest first
  reg raw_on = 1'b0; // Programme path expected unfiltered
  reg [47:0] pgm_q[$]; // Expected programme samples, B over A
  reg [47:0] pgm_exp;
  wire [31:0] rdata;
  wire smp_stb, aes_lock, pgm_stb, flt_a, flt_b, flt_any, irq;
  wire [23:0] ana_a, ana_b, aes_a, aes_b, pgm_a, pgm_b;
  integer fails = 0;
  integer checks = 0;
  integer cnt_exp = 0;
  integer dt;
  integer i;
  always #10 clk = ~clk;
  ptm_monitor #(.MS_CYC(MS)) i_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_SMP_STB(smp_stb), .I_ANA_A(ana_a), .I_ANA_B(ana_b), .I_AES_A(aes_a),
    .I_AES_B(aes_b), .I_AES_LOCK(aes_lock), .O_PGM_STB(pgm_stb), .O_PGM_A(pgm_a), .O_PGM_B(pgm_b),
    .O_FAULT_A(flt_a), .O_FAULT_B(flt_b), .O_INPUT_SUPERVISION_FAULT(flt_any), .O_IRQ(irq));
  ptm_src i_src (.i_clk(clk), .i_rst_b(rst_b), .i_tone_on(tone_on), .i_lock_on(lock_on), .o_stb(smp_stb),
    .o_ana_a(ana_a), .o_ana_b(ana_b), .o_aes_a(aes_a), .o_aes_b(aes_b), .o_lock(aes_lock));
  // Compare and count
  task chk(input string name, input [31:0] seen, input [31:0] expv);
    begin
      checks = checks + 1;
      if (seen !== expv) begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", name, expv, seen);
      end
    end
  endtask
  // Verdict and end of run
  task conclude;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // One-cycle write strobe
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // One-cycle read strobe; the answer is noted first
  task rd_reg(input [3:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
  // Let edges pass, then sample settled outputs
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // Bounded wait for a fault pattern; running out ends the run
  task wait_flt(input [1:0] expv, input integer lim);
    integer n;
    begin
      n = 0;
      while ({flt_b, flt_a} !== expv && n < lim) begin
        cyc(1);
        n = n + 1;
      end
      chk("fault", {30'h0, flt_b, flt_a}, {30'h0, expv});
      if ({flt_b, flt_a} !== expv) conclude;
    end
  endtask
  // Read answers against the oldest note; data sampled before the slot ends
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("rdata", rdata, exp_q.pop_front());
    end
  end
  // Stream samples noted at the strobe, compared when the programme strobe shows them
  always @(posedge clk) begin
    if (raw_on && smp_stb) pgm_q.push_back({aes_b, aes_a});
    if (pgm_stb && pgm_q.size() != 0) begin
      pgm_exp = pgm_q.pop_front();
      chk("programme a", {8'h0, pgm_a}, {8'h0, pgm_exp[23:0]});
      chk("programme b", {8'h0, pgm_b}, {8'h0, pgm_exp[47:24]});
    end
  end
  // Main sequence
  initial begin
    rnd = $urandom(37);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, clamping, read-only and unmapped words
    rd_reg(`PTM_ADR_CTRL, 32'h0);
    rd_reg(`PTM_ADR_DTIME, 32'h3E8);
    rd_reg(`PTM_ADR_TUNE_A, 32'h14004A38);
    rd_reg(`PTM_ADR_THR, 32'hD6D6);
    rd_reg(4'hF, 32'h0);
    wr_reg(`PTM_ADR_TUNE_A, 32'h00800000);
    rd_reg(`PTM_ADR_TUNE_A, 32'h049C0001);
    wr_reg(`PTM_ADR_TUNE_B, 32'h3F7F7FFF);
    rd_reg(`PTM_ADR_TUNE_B, 32'h2A644E20);
    wr_reg(`PTM_ADR_THR, 32'h807F);
    rd_reg(`PTM_ADR_THR, 32'h8615);
    wr_reg(`PTM_ADR_COUNT, 32'hFFFF);
    rd_reg(`PTM_ADR_COUNT, 32'h0);
    rnd = $urandom & 32'hF;
    wr_reg(`PTM_ADR_ENA, rnd);
    rd_reg(`PTM_ADR_ENA, rnd);
    wr_reg(`PTM_ADR_ENA, 32'h0);
    cyc(4);
    $display("test registers done");
    // Digital types in analogue input mode fault both inputs at once
    for (i = 1; i < 3; i = i + 1) begin
      wr_reg(`PTM_ADR_CTRL, i * 2);
      wr_reg(`PTM_ADR_ENA, 32'h3);
      wait_flt(2'h3, 6);
      chk("any fault", {31'h0, flt_any}, 32'h1);
      wr_reg(`PTM_ADR_ENA, 32'h0);
      wait_flt(2'h0, 6);
      cnt_exp = cnt_exp + 1;
    end
    wr_reg(`PTM_ADR_CTRL, 32'h6);
    rd_reg(`PTM_ADR_CTRL, 32'h0);
    rd_reg(`PTM_ADR_ISTAT, 32'h3);
    rd_reg(`PTM_ADR_COUNT, cnt_exp);
    cyc(3);
    chk("masked irq", {31'h0, irq}, 32'h0);
    $display("test unavailable done");
    // Lock gap longer than the detection time, then lock returns
    dt = 3 + ($urandom % 4);
    wr_reg(`PTM_ADR_DTIME, dt);
    rd_reg(`PTM_ADR_DTIME, dt);
    lock_on <= 1'b1;
    wr_reg(`PTM_ADR_CTRL, 32'h5);
    wr_reg(`PTM_ADR_ENA, 32'h1);
    raw_on <= 1'b1;
    cyc(4 * MS);
    chk("locked", {30'h0, flt_b, flt_a}, 32'h0);
    lock_on <= 1'b0;
    cyc(dt * MS - 8);
    chk("early", {30'h0, flt_b, flt_a}, 32'h0);
    wait_flt(2'h1, 4 * MS + 10);
    cnt_exp = cnt_exp + 1;
    rd_reg(`PTM_ADR_COUNT, cnt_exp);
    cyc(2);
    chk("irq off", {31'h0, irq}, 32'h0);
    wr_reg(`PTM_ADR_IMASK, 32'h1);
    cyc(3);
    chk("irq on", {31'h0, irq}, 32'h1);
    rd_reg(`PTM_ADR_ISTAT, 32'h1);
    cyc(4);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    lock_on <= 1'b1;
    wait_flt(2'h0, 10);
    raw_on <= 1'b0;
    $display("test lock done");
    // Mid-run reset with silent sources, so every filter restarts from rest
    tone_on <= 1'b0;
    cyc(4);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cnt_exp = 0;
    rd_reg(`PTM_ADR_DTIME, 32'h3E8);
    wr_reg(`PTM_ADR_DTIME, dt);
    // Silent analogue input B with its pilot missing
    wr_reg(`PTM_ADR_CTRL, 32'h0);
    wr_reg(`PTM_ADR_ENA, 32'hC);
    wr_reg(`PTM_ADR_ENA, 32'hE);
    wait_flt(2'h2, (dt + 3) * MS);
    cnt_exp = cnt_exp + 1;
    rd_reg(`PTM_ADR_COUNT, cnt_exp);
    rd_reg(`PTM_ADR_LEVEL, 32'h8080);
    wr_reg(`PTM_ADR_ENA, 32'h0);
    wait_flt(2'h0, 6);
    $display("test analogue pilot done");
    // Digital pilot on stream channel A, also silent
    wr_reg(`PTM_ADR_CTRL, 32'h3);
    wr_reg(`PTM_ADR_ENA, 32'h1);
    wait_flt(2'h1, (dt + 3) * MS);
    cnt_exp = cnt_exp + 1;
    rd_reg(`PTM_ADR_COUNT, cnt_exp);
    rd_reg(`PTM_ADR_ISTAT, 32'h3);
    cyc(4);
    $display("test digital pilot done");
    conclude;
  end
endmodule // test_pilot_tone_input_monitor
